// >>> pkg/cidt_pkg.sv
package cidt_pkg;

    localparam int          CIDT_WORD_W           = 16;
    localparam int          CIDT_PERIODS_PER_CYC  = 4;
    localparam int          CIDT_TARGET_W         = 20;
    localparam int          CIDT_ADDR_W           = 12;

    localparam int          CIDT_NIB_POS          = 12;
    localparam int          CIDT_SUB_POS          = 8;
    localparam int          CIDT_OPC_POS          = 10;
    localparam int          CIDT_DEST_POS         = 9;
    localparam int          CIDT_ACC_POS          = 8;
    localparam int          CIDT_BITN_POS         = 9;
    localparam int          CIDT_PTR_POS          = 4;
    localparam int          CIDT_SHADOW_CALL_POS  = 8;
    localparam int          CIDT_SHADOW_RET_POS   = 0;

    localparam logic [3:0]  CIDT_NIB_CTRL         = 4'h0;
    localparam logic [3:0]  CIDT_NIB_BYTE_LO      = 4'h1;
    localparam logic [3:0]  CIDT_NIB_BYTE_SKIP    = 4'h6;
    localparam logic [3:0]  CIDT_NIB_BIT_LO       = 4'h7;
    localparam logic [3:0]  CIDT_NIB_BIT_SKIP_LO  = 4'ha;
    localparam logic [3:0]  CIDT_NIB_BIT_HI       = 4'hb;
    localparam logic [3:0]  CIDT_NIB_MOVE         = 4'hc;
    localparam logic [3:0]  CIDT_NIB_BRANCH       = 4'hd;
    localparam logic [3:0]  CIDT_NIB_WIDE         = 4'he;
    localparam logic [3:0]  CIDT_NIB_SECOND       = 4'hf;

    localparam logic [3:0]  CIDT_SUB_PTR_LOAD     = 4'he;
    localparam logic [3:0]  CIDT_SUB_GOTO         = 4'hf;
    localparam logic [2:0]  CIDT_SUB_CALL         = 3'h6;
    localparam logic [1:0]  CIDT_SUB_EXT          = 2'h2;
    localparam logic [4:0]  CIDT_CTRL_TABLE       = 5'h01;
    localparam logic [6:0]  CIDT_CTRL_RETURN      = 7'h08;
    localparam logic [7:0]  CIDT_CTRL_NOP         = 8'h00;

    localparam logic [1:0]  CIDT_CYC_ONE          = 2'h1;
    localparam logic [1:0]  CIDT_CYC_TWO          = 2'h2;
    localparam logic [1:0]  CIDT_CYC_THREE        = 2'h3;

    typedef enum logic [1:0] {
        CIDT_CLASS_BYTE = 2'b00,
        CIDT_CLASS_BIT  = 2'b01,
        CIDT_CLASS_LIT  = 2'b10,
        CIDT_CLASS_CTRL = 2'b11
    } cidt_class_e;

    typedef enum logic [1:0] {
        CIDT_WIDE_MOVE = 2'b00,
        CIDT_WIDE_CALL = 2'b01,
        CIDT_WIDE_PTR  = 2'b10,
        CIDT_WIDE_GOTO = 2'b11
    } cidt_wide_e;

    typedef enum logic [0:0] {
        CIDT_ST_RUN   = 1'b0,
        CIDT_ST_WORD2 = 1'b1
    } cidt_state_e;

endpackage

// >>> verilog/cidt_cycle_timer.sv
`timescale 1ns/1ns
`default_nettype none
module cidt_cycle_timer
    import cidt_pkg::*;
#(
    parameter int PERIODS = CIDT_PERIODS_PER_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    output logic [1:0]      phase_o,
    output logic            cycle_start_o
);

    localparam int            CNT_W   = (PERIODS > 1) ? $clog2(PERIODS) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIODS - 1);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    // One instruction cycle spans a fixed number of oscillator periods.
    assign next_cnt      = (cnt == CNT_LAST) ? '0 : cnt + CNT_W'(1);
    assign cycle_start_o = (cnt == '0);
    assign phase_o       = 2'(cnt);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule
`default_nettype wire

// >>> verilog/cidt_decoder.sv
// How it works
// - Decode the standard set plus an extended group of eight instructions.
// - Nearly every instruction is one sixteen-bit program word.
// - A single word splits into an opcode plus qualifying operand fields.
// - Every instruction is classed as byte, bit, literal or control.
// - Four instructions take two words; both are assembled before execution.
// - A lone second word, top four bits ones, executes as no operation.
// - Single-word byte operations carry file address, destination bit and access bit; the two-word move carries two file addresses.
// - Destination zero writes the working register, one writes the file register.
// - Bit operations carry file address, access bit and bit number.
// - Literal operations carry a constant, maybe a pointer select, or nothing.
// - Control operations carry target address, shadow select, table mode, or nothing.
// - Single word takes one cycle, two when skipping or changing the PC.
// - Two-word moves and pointer loads take two instruction cycles; calls and gotos take three.
// - One instruction cycle equals four oscillator periods.
// - A taken two-word branch takes three instruction cycles in total.
// - Access bit clear selects the shared bank; set uses the bank select register.
// - Shadow select set saves or restores shadow copies; clear leaves them.
`timescale 1ns/1ns
`default_nettype none
module cidt_decoder
    import cidt_pkg::*;
#(
    parameter int PERIODS = CIDT_PERIODS_PER_CYC
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rst_i,
    input  wire logic [CIDT_WORD_W-1:0]    instr_word_i,
    input  wire logic                      instr_valid_i,
    input  wire logic                      cond_true_i,
    input  wire logic                      pc_write_i,
    output logic [1:0]                     phase_o,
    output logic                           cycle_start_o,
    output logic                           fetch_req_o,
    output logic                           flush_o,
    output logic                           exec_o,
    output logic                           no_operation_o,
    output logic                           two_word_o,
    output logic                           ext_o,
    output logic [1:0]                     class_o,
    output logic [5:0]                     opcode_o,
    output logic [CIDT_ADDR_W-1:0]         file_addr_o,
    output logic [CIDT_ADDR_W-1:0]         dest_addr_o,
    output logic                           dest_file_o,
    output logic                           bank_select_register_en_o,
    output logic [2:0]                     bit_num_o,
    output logic [CIDT_ADDR_W-1:0]         literal_o,
    output logic [1:0]                     indirect_pointer_register_sel_o,
    output logic [CIDT_TARGET_W-1:0]       target_o,
    output logic                           shadow_en_o,
    output logic [1:0]                     table_mode_o,
    output logic [1:0]                     cycles_o
);

    cidt_state_e                 state;
    cidt_wide_e                  wide_kind;
    logic [CIDT_WORD_W-1:0]      word1;
    logic                        pend_exec;
    logic                        pend_uncond;
    logic                        pend_cond;

    logic                        cyc;
    logic [CIDT_WORD_W-1:0]      w;
    logic [3:0]                  nib;
    logic [3:0]                  sub;
    logic                        is_byte;
    logic                        is_bit;
    logic                        is_wide;
    logic                        is_call;
    logic                        is_ptr;
    logic                        is_goto;
    logic                        is_move;
    logic                        first_of_two;
    logic                        is_second;
    logic                        is_ext;
    logic                        is_cond_br;
    logic                        ctrl_zero;
    logic                        is_table;
    logic                        is_return;
    logic                        is_branch;
    logic                        is_lit;
    logic                        is_nop1;
    logic                        is_skip;
    logic                        uncond1;
    logic                        cond1;
    logic                        redirect;
    logic                        take_single;
    logic                        take_second;
    cidt_wide_e                  kind1;
    cidt_class_e                 class1;
    cidt_class_e                 class2;

    logic [1:0]                  next_class;
    logic [5:0]                  next_opcode;
    logic [CIDT_ADDR_W-1:0]      next_file_addr;
    logic [CIDT_ADDR_W-1:0]      next_dest_addr;
    logic [CIDT_ADDR_W-1:0]      next_literal;
    logic [CIDT_TARGET_W-1:0]    next_target;
    logic [1:0]                  next_ptr_sel;
    logic                        next_shadow;
    logic [1:0]                  next_cycles;
    logic                        next_uncond;

    cidt_cycle_timer #(
        .PERIODS       (PERIODS)
    ) u_timer (
        .clk_sys_i     (clk_sys_i),
        .rst_i         (rst_i),
        .phase_o       (phase_o),
        .cycle_start_o (cyc)
    );

    assign cycle_start_o = cyc;
    assign fetch_req_o   = cyc;

    // Sixteen-bit word split into an opcode nibble and operand fields.
    assign w            = instr_word_i;
    assign nib          = w[CIDT_NIB_POS +: 4];
    assign sub          = w[CIDT_SUB_POS +: 4];
    assign is_byte      = (nib >= CIDT_NIB_BYTE_LO) && (nib <= CIDT_NIB_BYTE_SKIP);
    assign is_bit       = (nib >= CIDT_NIB_BIT_LO) && (nib <= CIDT_NIB_BIT_HI);
    assign is_wide      = (nib == CIDT_NIB_WIDE);
    assign is_move      = (nib == CIDT_NIB_MOVE);
    assign is_call      = is_wide && (sub[3:1] == CIDT_SUB_CALL);
    assign is_ptr       = is_wide && (sub == CIDT_SUB_PTR_LOAD);
    assign is_goto      = is_wide && (sub == CIDT_SUB_GOTO);
    assign first_of_two = is_move || is_call || is_ptr || is_goto;
    assign is_second    = (nib == CIDT_NIB_SECOND);
    assign is_ext       = is_wide && (sub[3:2] == CIDT_SUB_EXT);
    assign is_cond_br   = is_wide && !sub[3];
    assign ctrl_zero    = (nib == CIDT_NIB_CTRL) && (sub == 4'h0);
    assign is_table     = ctrl_zero && (w[7:3] == CIDT_CTRL_TABLE);
    assign is_return    = ctrl_zero && (w[7:1] == CIDT_CTRL_RETURN);
    assign is_branch    = (nib == CIDT_NIB_BRANCH);
    assign is_lit       = ((nib == CIDT_NIB_CTRL) && (sub != 4'h0)) || is_ext;
    assign is_nop1      = (ctrl_zero && (w[7:0] == CIDT_CTRL_NOP)) || is_second;
    assign is_skip      = (nib == CIDT_NIB_BYTE_SKIP) || (nib == CIDT_NIB_BIT_SKIP_LO) || (nib == CIDT_NIB_BIT_HI);
    assign uncond1      = is_branch || is_return;
    assign cond1        = is_skip || is_cond_br;

    assign class1 = is_byte ? CIDT_CLASS_BYTE :
                    is_bit  ? CIDT_CLASS_BIT  :
                    is_lit  ? CIDT_CLASS_LIT  : CIDT_CLASS_CTRL;
    assign class2 = (wide_kind == CIDT_WIDE_MOVE) ? CIDT_CLASS_BYTE :
                    (wide_kind == CIDT_WIDE_PTR)  ? CIDT_CLASS_LIT  : CIDT_CLASS_CTRL;
    assign kind1  = is_move ? CIDT_WIDE_MOVE :
                    is_call ? CIDT_WIDE_CALL :
                    is_ptr  ? CIDT_WIDE_PTR  : CIDT_WIDE_GOTO;

    // A pending redirect cancels the word fetched during the executing cycle.
    assign redirect    = pend_uncond || (pend_cond && cond_true_i) || (pend_exec && pc_write_i);
    assign take_single = cyc && !redirect && (state == CIDT_ST_RUN) && instr_valid_i && !first_of_two;
    assign take_second = cyc && !redirect && (state == CIDT_ST_WORD2) && instr_valid_i;

    assign next_class     = take_second ? class2 : class1;
    assign next_opcode    = take_second ? word1[CIDT_OPC_POS +: 6] : w[CIDT_OPC_POS +: 6];
    assign next_file_addr = take_second ? word1[CIDT_ADDR_W-1:0] : {4'h0, w[7:0]};
    assign next_dest_addr = take_second ? w[CIDT_ADDR_W-1:0] : {4'h0, w[7:0]};
    assign next_literal   = take_second ? {word1[3:0], w[7:0]} : {4'h0, w[7:0]};
    assign next_ptr_sel   = take_second ? word1[CIDT_PTR_POS +: 2] : 2'h0;
    assign next_target    = take_second ? {w[CIDT_ADDR_W-1:0], word1[7:0]} :
                            is_branch   ? {9'h000, w[10:0]} : {12'h000, w[7:0]};
    // Shadow copies are touched only when the call or return shadow bit is set.
    assign next_shadow    = take_second ? ((wide_kind == CIDT_WIDE_CALL) && word1[CIDT_SHADOW_CALL_POS]) :
                            (is_return && w[CIDT_SHADOW_RET_POS]);
    assign next_uncond    = (wide_kind == CIDT_WIDE_CALL) || (wide_kind == CIDT_WIDE_GOTO);
    assign next_cycles    = take_second ? (next_uncond ? CIDT_CYC_THREE : CIDT_CYC_TWO) :
                            (uncond1 ? CIDT_CYC_TWO : CIDT_CYC_ONE);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state       <= CIDT_ST_RUN;
            wide_kind   <= CIDT_WIDE_MOVE;
            word1       <= '0;
            pend_exec   <= 1'b0;
            pend_uncond <= 1'b0;
            pend_cond   <= 1'b0;
            flush_o     <= 1'b0;
            exec_o      <= 1'b0;
        end else begin
            flush_o <= 1'b0;
            exec_o  <= 1'b0;
            if (cyc) begin
                pend_exec   <= take_single || take_second;
                pend_uncond <= (take_single && uncond1) || (take_second && next_uncond);
                pend_cond   <= take_single && cond1;
                exec_o      <= take_single || take_second;
                flush_o     <= redirect;
                if (redirect) begin
                    state <= CIDT_ST_RUN;
                end else begin
                    case (state)
                        CIDT_ST_RUN: begin
                            if (instr_valid_i && first_of_two) begin
                                word1     <= w;
                                wide_kind <= kind1;
                                state     <= CIDT_ST_WORD2;
                            end
                        end
                        CIDT_ST_WORD2: begin
                            if (instr_valid_i) begin
                                state <= CIDT_ST_RUN;
                            end
                        end
                        default: begin
                            state <= CIDT_ST_RUN;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            no_operation_o                  <= 1'b0;
            two_word_o                      <= 1'b0;
            ext_o                           <= 1'b0;
            class_o                         <= CIDT_CLASS_CTRL;
            opcode_o                        <= '0;
            file_addr_o                     <= '0;
            dest_addr_o                     <= '0;
            dest_file_o                     <= 1'b0;
            bank_select_register_en_o       <= 1'b0;
            bit_num_o                       <= '0;
            literal_o                       <= '0;
            indirect_pointer_register_sel_o <= '0;
            target_o                        <= '0;
            shadow_en_o                     <= 1'b0;
            table_mode_o                    <= '0;
            cycles_o                        <= CIDT_CYC_ONE;
        end else if (cyc && redirect) begin
            no_operation_o <= 1'b1;
            cycles_o       <= CIDT_CYC_ONE;
        end else if (take_single || take_second) begin
            no_operation_o                  <= take_single && is_nop1;
            two_word_o                      <= take_second;
            ext_o                           <= take_single && is_ext;
            class_o                         <= next_class;
            opcode_o                        <= next_opcode;
            file_addr_o                     <= next_file_addr;
            dest_addr_o                     <= next_dest_addr;
            // Destination bit: zero targets the working register, one the file register.
            dest_file_o                     <= !take_second && w[CIDT_DEST_POS];
            // Access bit clear: shared bank, bank select register ignored.
            bank_select_register_en_o       <= !take_second && w[CIDT_ACC_POS];
            bit_num_o                       <= w[CIDT_BITN_POS +: 3];
            literal_o                       <= next_literal;
            indirect_pointer_register_sel_o <= next_ptr_sel;
            target_o                        <= next_target;
            shadow_en_o                     <= next_shadow;
            table_mode_o                    <= is_table ? w[1:0] : 2'h0;
            cycles_o                        <= next_cycles;
        end else if (cyc) begin
            no_operation_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> dv/cidt_decoder_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cidt_decoder_chk
    import cidt_pkg::*;
#(
    parameter int PERIODS = CIDT_PERIODS_PER_CYC
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire logic [CIDT_WORD_W-1:0] instr_word_i,
    input  wire logic                   instr_valid_i,
    input  wire logic                   pc_write_i,
    input  wire logic [1:0]             phase_o,
    input  wire logic                   cycle_start_o,
    input  wire logic                   flush_o,
    input  wire logic                   exec_o,
    input  wire logic                   no_operation_o,
    input  wire logic                   two_word_o,
    input  wire logic [1:0]             class_o,
    input  wire logic [5:0]             opcode_o,
    input  wire logic                   dest_file_o,
    input  wire logic                   bank_select_register_en_o,
    input  wire logic [2:0]             bit_num_o,
    input  wire logic [1:0]             cycles_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_taken;
        $past(cycle_start_o && instr_valid_i);
    endsequence
    sequence s_exec_redirect;
        exec_o ##3 (cycle_start_o && pc_write_i && instr_valid_i);
    endsequence

    property p_cycle_len;
        cycle_start_o |=> !cycle_start_o [*3] ##1 cycle_start_o;
    endproperty
    property p_phase_step;
        phase_o != 2'h3 |=> phase_o == $past(phase_o) + 2'h1;
    endproperty
    property p_exec_taken;
        exec_o |-> s_taken;
    endproperty
    property p_exec_gap;
        exec_o |=> !exec_o [*3];
    endproperty
    property p_flush_nop;
        flush_o |-> no_operation_o && !exec_o && cycles_o == CIDT_CYC_ONE;
    endproperty
    property p_redirect;
        s_exec_redirect |=> flush_o;
    endproperty
    property p_opcode;
        exec_o && !two_word_o && !no_operation_o |-> opcode_o == $past(instr_word_i[15:10]);
    endproperty
    property p_byte_fields;
        exec_o && class_o == CIDT_CLASS_BYTE |-> (two_word_o && !dest_file_o && !bank_select_register_en_o) ||
            (!two_word_o && dest_file_o == $past(instr_word_i[CIDT_DEST_POS])
            && bank_select_register_en_o == $past(instr_word_i[CIDT_ACC_POS]));
    endproperty
    property p_bit_fields;
        exec_o && class_o == CIDT_CLASS_BIT |-> bit_num_o == $past(instr_word_i[11:9]);
    endproperty
    property p_two_word;
        exec_o && two_word_o |-> $past(instr_word_i[15:12]) == CIDT_NIB_SECOND && cycles_o != CIDT_CYC_ONE;
    endproperty

    a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");
    a_phase_step: assert property (p_phase_step) else $error("phase step wrong");
    a_exec_taken: assert property (p_exec_taken) else $error("exec without taken word");
    a_exec_gap: assert property (p_exec_gap) else $error("exec too close");
    a_flush_nop: assert property (p_flush_nop) else $error("flush without no-op");
    a_redirect: assert property (p_redirect) else $error("redirect not flushed");
    a_opcode: assert property (p_opcode) else $error("opcode field wrong");
    a_byte_fields: assert property (p_byte_fields) else $error("byte fields wrong");
    a_bit_fields: assert property (p_bit_fields) else $error("bit number wrong");
    a_two_word: assert property (p_two_word) else $error("two-word exec wrong");
endmodule
bind cidt_decoder cidt_decoder_chk #(.PERIODS(PERIODS)) cidt_decoder_chk_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_word_i(instr_word_i), .instr_valid_i(instr_valid_i),
    .pc_write_i(pc_write_i), .phase_o(phase_o), .cycle_start_o(cycle_start_o), .flush_o(flush_o),
    .exec_o(exec_o), .no_operation_o(no_operation_o), .two_word_o(two_word_o), .class_o(class_o),
    .opcode_o(opcode_o), .dest_file_o(dest_file_o), .bit_num_o(bit_num_o), .cycles_o(cycles_o),
    .bank_select_register_en_o(bank_select_register_en_o));
`default_nettype wire

// >>> dv/cidt_fetch_model.sv
`timescale 1ns/1ns
`default_nettype none
module cidt_fetch_model
    import cidt_pkg::*;
(
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire logic                   go_i,
    input  wire logic [2:0]             len_i,
    input  wire logic                   fetch_i,
    output logic [CIDT_WORD_W-1:0]      word_o,
    output logic                        valid_o
);
    logic [CIDT_WORD_W-1:0] prog [8];
    logic [2:0]             ptr;

    initial begin
        for (int i = 0; i < 8; i++) begin
            prog[i] = 16'h0000;
        end
    end
    // Program words are handed over one per accepted fetch, in order.
    assign valid_o = go_i && (ptr < len_i);
    // Outside the program the data lines carry the inverse of the word.
    assign word_o  = valid_o ? prog[ptr] : ~prog[ptr];
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ptr <= 3'h0;
        end else if (!go_i) begin
            ptr <= 3'h0;
        end else if (fetch_i && valid_o) begin
            ptr <= ptr + 3'h1;
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb_core_instruction_decode_timing.sv
`timescale 1ns/1ns
`default_nettype none
module tb_core_instruction_decode_timing
    import cidt_pkg::*;
;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, go = 1'b0, cond_true_i = 1'b0, pc_write_i = 1'b0;
    logic [2:0]  len = 3'h0, bit_num_o;
    logic [15:0] instr_word_i;
    logic [1:0]  phase_o, class_o, indirect_pointer_register_sel_o, table_mode_o, cycles_o, s_cyc;
    logic        instr_valid_i, cycle_start_o, fetch_req_o, flush_o, exec_o, no_operation_o, two_word_o;
    logic        ext_o, dest_file_o, bank_select_register_en_o, shadow_en_o, s_tw, s_nop;
    logic [5:0]  opcode_o;
    logic [11:0] file_addr_o, dest_addr_o, literal_o;
    logic [19:0] target_o;
    int          error_cnt = 0, check_count = 0, n_exec = 0, n_flush = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    cidt_decoder cidt_decoder_inst (.clk_sys_i, .rst_i, .instr_word_i, .instr_valid_i, .cond_true_i,
        .pc_write_i, .phase_o, .cycle_start_o, .fetch_req_o, .flush_o, .exec_o, .no_operation_o, .two_word_o,
        .ext_o, .class_o, .opcode_o, .file_addr_o, .dest_addr_o, .dest_file_o, .bank_select_register_en_o,
        .bit_num_o, .literal_o, .indirect_pointer_register_sel_o, .target_o, .shadow_en_o, .table_mode_o,
        .cycles_o);
    cidt_fetch_model cidt_fetch_model_inst (.clk_sys_i, .rst_i, .go_i(go), .len_i(len), .fetch_i(fetch_req_o),
        .word_o(instr_word_i), .valid_o(instr_valid_i));

    always @(posedge clk_sys_i) begin
        if (exec_o === 1'b1) begin
            n_exec++;
            s_cyc = cycles_o;
            s_tw = two_word_o;
            s_nop = no_operation_o;
        end
        if (flush_o === 1'b1) begin
            n_flush++;
        end
    end

    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic run(input logic [15:0] a, b, c, input logic [2:0] n, input logic ct, pw);
        int i;
        cidt_fetch_model_inst.prog[0] = a;
        cidt_fetch_model_inst.prog[1] = b;
        cidt_fetch_model_inst.prog[2] = c;
        @(posedge clk_sys_i);
        go <= 1'b0;
        cond_true_i <= ct;
        pc_write_i <= pw;
        @(posedge clk_sys_i);
        n_exec = 0;
        n_flush = 0;
        len <= n;
        go <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        for (i = 0; i < 100 && instr_valid_i !== 1'b0; i++) @(posedge clk_sys_i);
        if (i == 100) begin
            error_cnt++;
            results();
        end
        repeat (12) @(posedge clk_sys_i);
    endtask

    task automatic t_byte();
        run(16'h23a5, 16'h0000, 16'h0000, 3'h1, 1'b0, 1'b0);
        check("class", class_o, CIDT_CLASS_BYTE);
        check("opcode", opcode_o, 6'h08);
        check("faddr", file_addr_o[7:0], 8'ha5);
        check("dest", dest_file_o, 1'b1);
        check("bank", bank_select_register_en_o, 1'b1);
        check("cyc", s_cyc, CIDT_CYC_ONE);
        check("ext", ext_o, 1'b0);
        run(16'h205a, 16'h0000, 16'h0000, 3'h1, 1'b0, 1'b0);
        check("dest", dest_file_o, 1'b0);
        check("bank", bank_select_register_en_o, 1'b0);
    endtask

    task automatic t_bit_lit();
        run(16'h7b3c, 16'h0000, 16'h0000, 3'h1, 1'b0, 1'b0);
        check("class", class_o, CIDT_CLASS_BIT);
        check("bitn", bit_num_o, 3'h5);
        check("faddr", file_addr_o[7:0], 8'h3c);
        run(16'h057e, 16'h0000, 16'h0000, 3'h1, 1'b0, 1'b0);
        check("class", class_o, CIDT_CLASS_LIT);
        check("lit", literal_o[7:0], 8'h7e);
        run(16'he855, 16'h0000, 16'h0000, 3'h1, 1'b0, 1'b0);
        check("ext", ext_o, 1'b1);
    endtask

    task automatic t_ctrl();
        run(16'h000a, 16'h0000, 16'h0000, 3'h1, 1'b0, 1'b0);
        check("class", class_o, CIDT_CLASS_CTRL);
        check("tmode", table_mode_o, 2'h2);
        run(16'hd123, 16'h1000, 16'h0000, 3'h2, 1'b0, 1'b0);
        check("target", target_o, 20'h00123);
        check("cyc", s_cyc, CIDT_CYC_TWO);
        check("flush", n_flush[1:0], 2'h1);
        run(16'h0011, 16'h1000, 16'h0000, 3'h2, 1'b0, 1'b0);
        check("shadow", shadow_en_o, 1'b1);
        check("flush", n_flush[1:0], 2'h1);
        check("exec", n_exec[1:0], 2'h1);
        run(16'h0010, 16'h1000, 16'h0000, 3'h2, 1'b0, 1'b0);
        check("shadow", shadow_en_o, 1'b0);
        run(16'hf123, 16'h0000, 16'h0000, 3'h1, 1'b0, 1'b0);
        check("nop", s_nop, 1'b1);
        check("class", class_o, CIDT_CLASS_CTRL);
    endtask

    task automatic t_two_word();
        run(16'hef12, 16'hf345, 16'h1000, 3'h3, 1'b0, 1'b0);
        check("exec", n_exec[1:0], 2'h1);
        check("tw", s_tw, 1'b1);
        check("target", target_o, 20'h34512);
        check("cyc", s_cyc, CIDT_CYC_THREE);
        run(16'hc123, 16'hf456, 16'h0000, 3'h2, 1'b0, 1'b0);
        check("cyc", s_cyc, CIDT_CYC_TWO);
        check("src", file_addr_o, 12'h123);
        check("dst", dest_addr_o, 12'h456);
        check("flush", n_flush[1:0], 2'h0);
        run(16'hee25, 16'hf09a, 16'h0000, 3'h2, 1'b0, 1'b0);
        check("psel", indirect_pointer_register_sel_o, 2'h2);
        check("lit", literal_o, 12'h59a);
        run(16'hed34, 16'hf678, 16'h1000, 3'h3, 1'b0, 1'b0);
        check("shadow", shadow_en_o, 1'b1);
        check("target", target_o, 20'h67834);
        check("flush", n_flush[1:0], 2'h1);
    endtask

    task automatic t_redirect();
        run(16'h1000, 16'h6123, 16'h1000, 3'h3, 1'b1, 1'b0);
        check("exec", n_exec[1:0], 2'h2);
        check("flush", n_flush[1:0], 2'h1);
        run(16'h1000, 16'h6123, 16'h1000, 3'h3, 1'b0, 1'b0);
        check("exec", n_exec[1:0], 2'h3);
        run(16'he305, 16'h1000, 16'h0000, 3'h2, 1'b1, 1'b0);
        check("target", target_o, 20'h00005);
        check("flush", n_flush[1:0], 2'h1);
        run(16'h1111, 16'h1222, 16'h0000, 3'h2, 1'b0, 1'b1);
        check("exec", n_exec[1:0], 2'h1);
        check("flush", n_flush[1:0], 2'h1);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_i);
        check("cstart", cycle_start_o, 1'b1);
        check("freq", fetch_req_o, 1'b1);
        rst_i <= 1'b0;
        t_byte();
        t_bit_lit();
        t_ctrl();
        t_two_word();
        t_redirect();
        results();
    end
endmodule
`default_nettype wire
